//--- mscr_meas_model.sv
`timescale 1ns/100ps
`default_nettype none
// Converter and pin side: one-cycle result pulses, live pin levels
module mscr_meas_model
  import mscr_pkg::*;
(
  input  wire logic                 pclk,
  output logic                      cmp_valid,
  output logic [NUM_CELLS-1:0]      cmp_over,
  output logic [NUM_CELLS-1:0]      cmp_under,
  output logic                      osc_valid,
  output logic [7:0]                osc_count,
  output logic [NUM_PINS-1:0]       pin_level
);
  // Idle at time zero
  initial begin
    cmp_valid = 1'b0;
    cmp_over = '0;
    cmp_under = '0;
    osc_valid = 1'b0;
    osc_count = 8'h00;
    pin_level = '0;
  end
  // Data goes to the inverse once not valid, so stale values cannot pass
  task automatic send_cmp(input logic [15:0] ov, input logic [15:0] uv);
    @(posedge pclk);
    cmp_valid <= 1'b1;
    cmp_over <= ov;
    cmp_under <= uv;
    @(posedge pclk);
    cmp_valid <= 1'b0;
    cmp_over <= ~ov;
    cmp_under <= ~uv;
  endtask : send_cmp
  task automatic send_osc(input logic [7:0] c);
    @(posedge pclk);
    osc_valid <= 1'b1;
    osc_count <= c;
    @(posedge pclk);
    osc_valid <= 1'b0;
    osc_count <= ~c;
  endtask : send_osc
  task automatic set_pins(input logic [NUM_PINS-1:0] v);
    @(posedge pclk);
    pin_level <= v;
  endtask : set_pins
endmodule : mscr_meas_model
`default_nettype wire

//--- mscr_pkg.sv
package mscr_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] ADDR_CELL_FLAGS_LO  = 8'h00;
  localparam logic [7:0] ADDR_CELL_FLAGS_HI  = 8'h04;
  localparam logic [7:0] ADDR_PIN_STATE      = 8'h08;
  localparam logic [7:0] ADDR_DUTY_LO        = 8'h0c;
  localparam logic [7:0] ADDR_DUTY_HI        = 8'h10;
  localparam logic [7:0] ADDR_LPM_CFG        = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK       = 8'h1c;
  localparam logic [7:0] ADDR_CTRL           = 8'h20;

  localparam int NUM_CELLS = 16;
  localparam int NUM_PINS  = 10;
  localparam int DUTY_W    = 4;

  // Oscillator pass window, inclusive
  localparam logic [7:0] OSC_PASS_MIN = 8'h34;
  localparam logic [7:0] OSC_PASS_MAX = 8'h47;

  // Reset values
  localparam logic [15:0] LIMIT_FLAG_RST = 16'hffff;
  localparam logic [7:0]  OSC_COUNT_RST  = 8'h00;
  localparam logic [3:0]  DUTY_RST       = 4'h0;
  localparam logic [7:0]  DEV_COUNT_RST  = 8'h00;
  localparam logic [2:0]  PERIOD_SEL_RST = 3'h0;
  localparam logic        OSC_FLAG_RST   = 1'b1;

  // Fixed reserved field values in the pin-state word
  localparam logic [3:0] FIXED_ZERO_VAL = 4'h0;
  localparam logic [3:0] FIXED_ONE_VAL  = 4'hf;

  // Arbitrary revision value, no meaning
  localparam logic [3:0] REVISION_CODE = 4'h1;

  // Config word fields
  localparam int CFG_DEV_LSB   = 0;
  localparam int CFG_MAN_BIT   = 8;
  localparam int CFG_MPER_LSB  = 9;
  localparam int CFG_BTM_BIT   = 12;
  localparam int CFG_TPER_LSB  = 13;

  // Interrupt status bits
  localparam int IRQ_OV_BIT  = 0;
  localparam int IRQ_UV_BIT  = 1;
  localparam int IRQ_OSC_BIT = 2;
  localparam int IRQ_W       = 3;

  // Control word bits (write-one pulses)
  localparam int CTRL_OSC_CLR_BIT = 0;
  localparam int CTRL_OV_CLR_BIT  = 1;
  localparam int CTRL_UV_CLR_BIT  = 2;

endpackage : mscr_pkg

//--- mscr_props.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the register bank
module mscr_props
  import mscr_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        osc_valid,
  input wire logic [7:0]  osc_count,
  input wire logic        monitor_manager_enable,
  input wire logic [2:0]  heartbeat_period_sel,
  input wire logic [5:0]  heartbeat_period_s,
  input wire logic        bridgeless_timeout_enable,
  input wire logic [2:0]  bridgeless_timeout_sel,
  input wire logic [6:0]  bridgeless_timeout_half_s,
  input wire logic        osc_check_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Period tables; code 111 folds back to the shortest period
  localparam logic [5:0] HB_S[8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20, 6'h01};
  localparam logic [6:0] TO_H[8] = '{7'h03, 7'h06, 7'h0c, 7'h18, 7'h24, 7'h30, 7'h60, 7'h03};
  wire logic acc     = psel && penable;
  wire logic osc_bad = osc_valid && (osc_count < OSC_PASS_MIN || osc_count > OSC_PASS_MAX);
  wire logic cfg_wr  = acc && pwrite && paddr == ADDR_LPM_CFG && pstrb[1];

  a_osc_fail_sets: assert property (osc_bad |=> osc_check_flag)
    else $error("osc flag not set by bad count");
  a_osc_rise_cause: assert property ($rose(osc_check_flag) |-> $past(osc_bad))
    else $error("osc flag set by passing count");
  a_osc_clear_cmd: assert property ($fell(osc_check_flag) |-> $past(acc && pwrite && paddr == ADDR_CTRL && pwdata[0] && pstrb[0]))
    else $error("osc flag cleared without command");
  a_fixed_bits: assert property (acc && !pwrite && paddr == ADDR_PIN_STATE |-> prdata[31:14] == {10'h000, FIXED_ONE_VAL, FIXED_ZERO_VAL})
    else $error("fixed bits read wrong");
  a_man_write: assert property (cfg_wr |=> monitor_manager_enable == $past(pwdata[CFG_MAN_BIT]))
    else $error("manager enable not written");
  a_btm_write: assert property (cfg_wr |=> bridgeless_timeout_enable == $past(pwdata[CFG_BTM_BIT]))
    else $error("timeout enable not written");
  a_hb_decode: assert property (heartbeat_period_s == HB_S[heartbeat_period_sel])
    else $error("heartbeat period decode wrong");
  a_tmo_decode: assert property (bridgeless_timeout_half_s == TO_H[bridgeless_timeout_sel])
    else $error("timeout period decode wrong");

  c_osc_fail: cover property (osc_bad);
  c_osc_clear: cover property ($fell(osc_check_flag));
  c_cfg_write: cover property (cfg_wr);
endmodule : mscr_props

bind mscr_regs mscr_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .osc_valid(osc_valid),
  .osc_count(osc_count), .monitor_manager_enable(monitor_manager_enable),
  .heartbeat_period_sel(heartbeat_period_sel), .heartbeat_period_s(heartbeat_period_s),
  .bridgeless_timeout_enable(bridgeless_timeout_enable), .bridgeless_timeout_sel(bridgeless_timeout_sel),
  .bridgeless_timeout_half_s(bridgeless_timeout_half_s), .osc_check_flag(osc_check_flag));
`default_nettype wire

//--- mscr_pwm.sv
`timescale 1ns/100ps
`default_nettype none
// One balancing channel: duty of code/15 on a 15-slot frame
module mscr_pwm
  import mscr_pkg::*;
#(
  parameter int W = DUTY_W
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         slot_en,
  input  wire logic [W-1:0] phase,
  input  wire logic [W-1:0] code,
  output logic              drive
);

  // Phase runs 0..14, so code 15 is always on and 0 always off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive <= 1'b0;
    end else if (slot_en) begin
      drive <= (phase < code);
    end
  end

endmodule : mscr_pwm
`default_nettype wire

//--- mscr_regs.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Each cell overvoltage flag is set by the 1 ms converter compare and reads 1 after reset.
// - Each cell undervoltage flag is set by the 1 ms converter compare and reads 1 after reset.
// - The oscillator count holds after reset until a clear, then follows each new count until a failure, then holds the first failing count.
// - Counts 52 to 71 inclusive pass and any other count is a failure.
// - Pin level bits are read-only, show the pin level after a two-stage synchroniser and reset to 0.
// - Fixed-zero bits read 0, fixed-one bits read 1, other reserved bits read 0 here.
// - Each cell has a 4-bit duty code, 1111 full, 0001 one fifteenth, 0000 off, reset 0000.
// - The manager bit enables the fault-monitoring manager role and resets to 0.
// - The heartbeat select picks 1,2,4,8,12,16,32,1 s and resets to 000.
// - The bridgeless timeout enable runs the timeout monitor and resets to 0.
// - The bridgeless timeout select picks 1.5,3,6,12,18,24,48,1.5 s and resets to 000.
// - An out-of-range count during a conversion sets the oscillator check flag.
// - The oscillator check flag clears only on the clear command with the oscillator select set.
module mscr_regs
  import mscr_pkg::*;
#(
  parameter int PWM_SLOT_DIV = 40
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   cmp_valid,
  input  wire logic [NUM_CELLS-1:0]   cmp_over,
  input  wire logic [NUM_CELLS-1:0]   cmp_under,
  input  wire logic                   osc_valid,
  input  wire logic [7:0]             osc_count,
  input  wire logic [NUM_PINS-1:0]    pin_level,
  output logic [NUM_CELLS-1:0]        balance_drive,
  output logic [7:0]                  chain_device_count,
  output logic                        monitor_manager_enable,
  output logic [2:0]                  heartbeat_period_sel,
  output logic [5:0]                  heartbeat_period_s,
  output logic                        bridgeless_timeout_enable,
  output logic [2:0]                  bridgeless_timeout_sel,
  output logic [6:0]                  bridgeless_timeout_half_s,
  output logic                        osc_check_flag,
  output logic                        irq
);

  logic [NUM_CELLS-1:0]        ov_q;
  logic [NUM_CELLS-1:0]        uv_q;
  logic [7:0]                  osc_cnt_q;
  logic                        osc_flag_q;
  logic [NUM_PINS-1:0]         pin_s1_q;
  logic [NUM_PINS-1:0]         pin_q;
  logic [NUM_CELLS*DUTY_W-1:0] duty_q;
  logic [7:0]                  ndev_q;
  logic                        man_q;
  logic [2:0]                  mper_q;
  logic                        btm_q;
  logic [2:0]                  tper_q;
  logic [IRQ_W-1:0]            ist_q;
  logic [IRQ_W-1:0]            imask_q;
  logic [31:0]                 rdata_q;
  logic [15:0]                 div_q;
  logic [DUTY_W-1:0]           phase_q;

  // Bus decode
  wire        acc      = psel & penable;
  wire        wr       = acc & pwrite;
  wire        rd       = acc & ~pwrite;
  wire        hit_fl0  = (paddr == ADDR_CELL_FLAGS_LO);
  wire        hit_fl1  = (paddr == ADDR_CELL_FLAGS_HI);
  wire        hit_pin  = (paddr == ADDR_PIN_STATE);
  wire        hit_d0   = (paddr == ADDR_DUTY_LO);
  wire        hit_d1   = (paddr == ADDR_DUTY_HI);
  wire        hit_cfg  = (paddr == ADDR_LPM_CFG);
  wire        hit_ist  = (paddr == ADDR_IRQ_STATUS);
  wire        hit_imk  = (paddr == ADDR_IRQ_MASK);
  wire        hit_ctl  = (paddr == ADDR_CTRL);
  wire        mapped   = hit_fl0 | hit_fl1 | hit_pin | hit_d0 | hit_d1 | hit_cfg | hit_ist | hit_imk | hit_ctl;
  wire [31:0] bmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] wmasked  = pwdata & bmask;

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = rdata_q;

  // Clear commands are write-one pulses on the control word
  wire        ctl_wr   = wr & hit_ctl;
  wire        osc_clr  = ctl_wr & wmasked[CTRL_OSC_CLR_BIT];
  wire        ov_clr   = ctl_wr & wmasked[CTRL_OV_CLR_BIT];
  wire        uv_clr   = ctl_wr & wmasked[CTRL_UV_CLR_BIT];

  // Oscillator window check
  wire        osc_pass = (osc_count >= OSC_PASS_MIN) && (osc_count <= OSC_PASS_MAX);
  wire        osc_fail = osc_valid & ~osc_pass;

  // Limit flags: a fresh compare sets, clear command drops unless set the same cycle
  wire [NUM_CELLS-1:0] ov_set = cmp_valid ? cmp_over : '0;
  wire [NUM_CELLS-1:0] uv_set = cmp_valid ? cmp_under : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_q <= LIMIT_FLAG_RST;
      uv_q <= LIMIT_FLAG_RST;
    end else begin
      ov_q <= ov_set | (ov_clr ? '0 : ov_q);
      uv_q <= uv_set | (uv_clr ? '0 : uv_q);
    end
  end

  // Count capture freezes at the first failure until the flag is cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_q  <= OSC_COUNT_RST;
      osc_flag_q <= OSC_FLAG_RST;
    end else begin
      if (osc_valid && (!osc_flag_q || osc_clr)) begin
        osc_cnt_q <= osc_count;
      end
      osc_flag_q <= osc_fail | (osc_flag_q & ~osc_clr);
    end
  end

  // Two-stage synchroniser for the pin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= '0;
      pin_q    <= '0;
    end else begin
      pin_s1_q <= pin_level;
      pin_q    <= pin_s1_q;
    end
  end

  // Writable config words with byte lanes
  wire [31:0] duty_lo_d = (duty_q[31:0] & ~bmask) | wmasked;
  wire [31:0] duty_hi_d = (duty_q[63:32] & ~bmask) | wmasked;
  wire [31:0] cfg_cur   = {16'h0, tper_q, btm_q, mper_q, man_q, ndev_q};
  wire [31:0] cfg_d     = (cfg_cur & ~bmask) | wmasked;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_q <= {NUM_CELLS{DUTY_RST}};
      ndev_q <= DEV_COUNT_RST;
      man_q  <= 1'b0;
      mper_q <= PERIOD_SEL_RST;
      btm_q  <= 1'b0;
      tper_q <= PERIOD_SEL_RST;
    end else begin
      if (wr && hit_d0) duty_q[31:0] <= duty_lo_d;
      if (wr && hit_d1) duty_q[63:32] <= duty_hi_d;
      if (wr && hit_cfg) begin
        ndev_q <= cfg_d[CFG_DEV_LSB +: 8];
        man_q  <= cfg_d[CFG_MAN_BIT];
        mper_q <= cfg_d[CFG_MPER_LSB +: 3];
        btm_q  <= cfg_d[CFG_BTM_BIT];
        tper_q <= cfg_d[CFG_TPER_LSB +: 3];
      end
    end
  end

  // Interrupt status: set wins over write-one clear
  wire [IRQ_W-1:0] ev  = {osc_fail, |uv_set, |ov_set};
  wire [IRQ_W-1:0] w1c = (wr && hit_ist) ? wmasked[IRQ_W-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q   <= '0;
      imask_q <= '0;
    end else begin
      ist_q <= ev | (ist_q & ~w1c);
      if (wr && hit_imk) imask_q <= wmasked[IRQ_W-1:0];
    end
  end
  assign irq = |(ist_q & imask_q);

  // Read mux; unused reserved bits read 0
  wire [31:0] pin_word = {10'h0, FIXED_ONE_VAL, FIXED_ZERO_VAL, REVISION_CODE, pin_q};
  wire [31:0] rd_mux =
      hit_fl0 ? {uv_q, ov_q} :
      hit_fl1 ? {23'h0, osc_flag_q, osc_cnt_q} :
      hit_pin ? pin_word :
      hit_d0  ? duty_q[31:0] :
      hit_d1  ? duty_q[63:32] :
      hit_cfg ? cfg_cur :
      hit_ist ? {29'h0, ist_q} :
      hit_imk ? {29'h0, imask_q} : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      rdata_q <= rd_mux; // Latched in setup so data is registered at access
    end
  end

  // PWM slot divider and phase 0..14
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q   <= '0;
      phase_q <= '0;
    end else if (div_q == 16'(PWM_SLOT_DIV - 1)) begin
      div_q   <= '0;
      phase_q <= (phase_q == 4'he) ? 4'h0 : phase_q + 4'h1;
    end else begin
      div_q <= div_q + 16'h1;
    end
  end
  wire slot_en = (div_q == 16'(PWM_SLOT_DIV - 1));

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CELLS; gi++) begin : g_pwm
      mscr_pwm #(.W(DUTY_W)) u_pwm (
        .pclk    (pclk),
        .presetn (presetn),
        .slot_en (slot_en),
        .phase   (phase_q),
        .code    (duty_q[gi*DUTY_W +: DUTY_W]),
        .drive   (balance_drive[gi])
      );
    end
  endgenerate

  // Decoded periods for the heartbeat and timeout engine
  always_comb begin
    unique case (mper_q)
      3'h0:    heartbeat_period_s = 6'd1;
      3'h1:    heartbeat_period_s = 6'd2;
      3'h2:    heartbeat_period_s = 6'd4;
      3'h3:    heartbeat_period_s = 6'd8;
      3'h4:    heartbeat_period_s = 6'd12;
      3'h5:    heartbeat_period_s = 6'd16;
      3'h6:    heartbeat_period_s = 6'd32;
      default: heartbeat_period_s = 6'd1;
    endcase
    unique case (tper_q) // in half seconds
      3'h0:    bridgeless_timeout_half_s = 7'd3;
      3'h1:    bridgeless_timeout_half_s = 7'd6;
      3'h2:    bridgeless_timeout_half_s = 7'd12;
      3'h3:    bridgeless_timeout_half_s = 7'd24;
      3'h4:    bridgeless_timeout_half_s = 7'd36;
      3'h5:    bridgeless_timeout_half_s = 7'd48;
      3'h6:    bridgeless_timeout_half_s = 7'd96;
      default: bridgeless_timeout_half_s = 7'd3;
    endcase
  end

  assign chain_device_count        = ndev_q;
  assign monitor_manager_enable    = man_q;
  assign heartbeat_period_sel      = mper_q;
  assign bridgeless_timeout_enable = btm_q;
  assign bridgeless_timeout_sel    = tper_q;
  assign osc_check_flag            = osc_flag_q;

endmodule : mscr_regs
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import mscr_pkg::*;
;
  localparam logic [5:0] HB_S[8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20, 6'h01};
  localparam logic [6:0] TO_H[8] = '{7'h03, 7'h06, 7'h0c, 7'h18, 7'h24, 7'h30, 7'h60, 7'h03};
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic                 cmp_valid, osc_valid, man, btm, osc_flag;
  logic [7:0]           paddr, osc_count, ndev;
  logic [31:0]          pwdata, prdata, rd, wv;
  logic [3:0]           pstrb;
  logic [15:0]          cmp_over, cmp_under, balance_drive;
  logic [9:0]           pin_level;
  logic [2:0]           hb_sel, to_sel;
  logic [5:0]           hb_s;
  logic [6:0]           to_h;
  int                   failures, total_checks, cyc, cnt[16];

  mscr_regs #(.PWM_SLOT_DIV(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_valid(cmp_valid), .cmp_over(cmp_over), .cmp_under(cmp_under),
    .osc_valid(osc_valid), .osc_count(osc_count), .pin_level(pin_level), .balance_drive(balance_drive),
    .chain_device_count(ndev), .monitor_manager_enable(man), .heartbeat_period_sel(hb_sel),
    .heartbeat_period_s(hb_s), .bridgeless_timeout_enable(btm), .bridgeless_timeout_sel(to_sel),
    .bridgeless_timeout_half_s(to_h), .osc_check_flag(osc_flag), .irq(irq));
  mscr_meas_model meas (.pclk(pclk), .cmp_valid(cmp_valid), .cmp_over(cmp_over), .cmp_under(cmp_under),
    .osc_valid(osc_valid), .osc_count(osc_count), .pin_level(pin_level));

  // 40 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Hang guard, far above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; read data taken at the pready edge, no local cycle limit (hang guard ends a stuck wait)
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk
  task automatic irq_chk(input logic exp);
    @(negedge pclk);
    chk(32'(irq), 32'(exp));
  endtask : irq_chk
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rchk(ADDR_CELL_FLAGS_LO, 32'hffffffff);
    rchk(ADDR_CELL_FLAGS_HI, 32'h00000100);
    rchk(ADDR_DUTY_LO, 32'h0);
    rchk(ADDR_LPM_CFG, 32'h0);
    // Pin levels pass a two-flop synchroniser; writes must not stick
    meas.set_pins(10'h2a5);
    apb(1'b1, ADDR_PIN_STATE, 32'hffffffff);
    rchk(ADDR_PIN_STATE, {10'h000, FIXED_ONE_VAL, FIXED_ZERO_VAL, REVISION_CODE, 10'h2a5});
    // Oscillator window edges, then freeze on first failure
    apb(1'b1, ADDR_IRQ_MASK, 32'h4);
    apb(1'b1, ADDR_CTRL, 32'h7);
    rchk(ADDR_CELL_FLAGS_HI, 32'h0);
    rchk(ADDR_CELL_FLAGS_LO, 32'h0);
    irq_chk(1'b0);
    meas.send_osc(8'h34);
    rchk(ADDR_CELL_FLAGS_HI, 32'h34);
    meas.send_osc(8'h47);
    rchk(ADDR_CELL_FLAGS_HI, 32'h47);
    meas.send_osc(8'h48);
    rchk(ADDR_CELL_FLAGS_HI, 32'h148);
    chk(32'(osc_flag), 32'h1);
    meas.send_osc(8'h40);
    rchk(ADDR_CELL_FLAGS_HI, 32'h148);
    irq_chk(1'b1);
    rchk(ADDR_IRQ_STATUS, 32'h4);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    irq_chk(1'b0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h4);
    irq_chk(1'b1);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h4);
    irq_chk(1'b0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    rchk(ADDR_CELL_FLAGS_HI, 32'h48);
    meas.send_osc(8'h33);
    rchk(ADDR_CELL_FLAGS_HI, 32'h133);
    // Limit flags accumulate across results
    meas.send_cmp(16'h0008, 16'h0020);
    meas.send_cmp(16'h0001, 16'h0000);
    rchk(ADDR_CELL_FLAGS_LO, 32'h00200009);
    // Every period code, with varied enables
    for (int i = 0; i < 8; i++) begin
      wv = {16'h0, i[2:0], i[0], i[2:0], i[1], 8'h42 + 8'(i)};
      apb(1'b1, ADDR_LPM_CFG, wv);
      rchk(ADDR_LPM_CFG, wv);
      chk(32'(hb_s), 32'(HB_S[i]));
      chk(32'(to_h), 32'(TO_H[i]));
      chk(32'({to_sel, btm, hb_sel, man, ndev}), wv);
    end
    // Duty over one 30-cycle frame is code times two
    apb(1'b1, ADDR_DUTY_LO, 32'h0000071f);
    apb(1'b1, ADDR_DUTY_HI, 32'hf0000000);
    rchk(ADDR_DUTY_LO, 32'h0000071f);
    repeat (30) begin
      @(negedge pclk);
      for (int k = 0; k < 16; k++) cnt[k] += int'(balance_drive[k]);
    end
    chk(cnt[0], 30);
    chk(cnt[1], 2);
    chk(cnt[2], 14);
    chk(cnt[3], 0);
    chk(cnt[15], 30);
    // Byte lanes: only lane 1 of the duty word may change
    pstrb <= 4'h2;
    apb(1'b1, ADDR_DUTY_LO, 32'hffffffff);
    pstrb <= 4'hf;
    rchk(ADDR_DUTY_LO, 32'h0000ff1f);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
